// file: core/pfpc_regs.sv
// Operation
// - Two 24-bit pin registers hold twelve 4-bit pin function fields.
// - Pins 0-5 in the low register, 6-11 high; field n at bits 4n+3:4n.
// - Top field bit set inverts the pin signal, input or output, for codes 1000-1100 only.
// - Pull-up on whenever a pin is a digital or serial input.
// - Codes 0000-0100: debounced in, raw in, push-pull, open-collector, serial.
// - Codes 1000-1100 select the same five functions, inverted.
// - Code 1111 routes the pin to the auxiliary converter.
// - Two-bit smoothing field selects hysteresis, bypass or filter bypass mode.
// - Enable bit, top of aux enable register, switches the aux converter on.
// - Oscillator power-down bit stops the crystal oscillator; clear lets it run.
//
// Purpose: Register bank for pin functions and power controls.
// Assumes: Plain register port; read data valid the cycle after the read strobe.
// Notes:   Unmapped addresses read zero and ignore writes.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module pfpc_regs
    import pfpc_pkg::*;
#(
    parameter int PINS = PFPC_PINS
) (
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic [PFPC_ADDR_W-1:0] addr_in,
    input  wire logic [PFPC_DATA_W-1:0] wdata_in,
    input  wire logic                   wr_in,
    input  wire logic                   rd_in,
    output logic      [PFPC_DATA_W-1:0] rdata_out,
    output logic      [PINS-1:0]        pin_invert_out,
    output logic      [PINS-1:0]        pin_pull_up_out,
    output logic      [PINS-1:0]        pin_debounce_out,
    output logic      [PINS-1:0]        pin_gp_input_out,
    output logic      [PINS-1:0]        pin_gp_output_out,
    output logic      [PINS-1:0]        pin_open_coll_out,
    output logic      [PINS-1:0]        pin_serial_out,
    output logic      [PINS-1:0]        pin_aux_analog_out,
    output logic      [1:0]             aux_smoothing_select_out,
    output logic                        main_converters_powerdown_out,
    output logic                        ref_buffer_powerdown_out,
    output logic                        ref_powerdown_out,
    output logic      [3:0]             dac_powerdown_out,
    output logic                        aux_converter_on_out,
    output logic                        osc_powerdown_out,
    output logic      [1:0]             dac_init_field_out
);
    logic [23:0] pin_function_low;
    logic [23:0] pin_function_high;
    logic [15:0] aux_filter_and_power_control;
    logic [15:0] aux_converter_enable;
    logic [15:0] oscillator_power_down;
    logic [15:0] dac_setup;
    logic [PFPC_DATA_W-1:0] next_rdata;

    pfpc_pin_if #(.PINS(PINS)) pin_ctl ();

    // Writes: each register stores only its defined bits.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pin_function_low  <= PFPC_PIN_RESET;
            pin_function_high <= PFPC_PIN_RESET;
        end else if (wr_in) begin
            if (addr_in == PFPC_PIN_LOW_ADDR) begin
                pin_function_low <= wdata_in;
            end
            if (addr_in == PFPC_PIN_HIGH_ADDR) begin
                pin_function_high <= wdata_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            aux_filter_and_power_control <= PFPC_REG16_RESET;
            aux_converter_enable         <= PFPC_REG16_RESET;
            oscillator_power_down        <= PFPC_REG16_RESET;
            dac_setup                    <= PFPC_REG16_RESET;
        end else if (wr_in) begin
            unique case (addr_in)
                PFPC_AUX_PWR_ADDR:
                    aux_filter_and_power_control <= wdata_in[15:0] & PFPC_AUX_PWR_MASK;
                PFPC_AUX_EN_ADDR:
                    aux_converter_enable <= wdata_in[15:0] & PFPC_AUX_EN_MASK;
                PFPC_OSC_PD_ADDR:
                    oscillator_power_down <= wdata_in[15:0] & PFPC_OSC_PD_MASK;
                // Reserved setup codes are stored as written; they are software's concern.
                PFPC_DAC_SETUP_ADDR:
                    dac_setup <= wdata_in[15:0] & PFPC_DAC_MASK;
                default: begin
                end
            endcase
        end
    end

    // Reads: narrower registers sit in the low bits, the rest read zero.
    always_comb begin
        next_rdata = '0;
        unique case (addr_in)
            PFPC_PIN_LOW_ADDR:   next_rdata = pin_function_low;
            PFPC_PIN_HIGH_ADDR:  next_rdata = pin_function_high;
            PFPC_AUX_PWR_ADDR:   next_rdata = {8'h00, aux_filter_and_power_control};
            PFPC_AUX_EN_ADDR:    next_rdata = {8'h00, aux_converter_enable};
            PFPC_OSC_PD_ADDR:    next_rdata = {8'h00, oscillator_power_down};
            PFPC_DAC_SETUP_ADDR: next_rdata = {8'h00, dac_setup};
            default:             next_rdata = '0;
        endcase
    end

    // Read data are held only in the cycle after the strobe, zero otherwise.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= '0;
        end else if (rd_in) begin
            rdata_out <= next_rdata;
        end else begin
            rdata_out <= '0;
        end
    end

    pfpc_pin_decode #(.PINS(PINS)) u_decode (
        .nibbles_in ({pin_function_high, pin_function_low}),
        .pins       (pin_ctl)
    );

    // Pin controls are registered so every output comes from a flip-flop.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pin_invert_out     <= '0;
            pin_pull_up_out    <= '0;
            pin_debounce_out   <= '0;
            pin_gp_input_out   <= '0;
            pin_gp_output_out  <= '0;
            pin_open_coll_out  <= '0;
            pin_serial_out     <= '0;
            pin_aux_analog_out <= '0;
        end else begin
            pin_invert_out     <= pin_ctl.invert;
            pin_pull_up_out    <= pin_ctl.pull_up;
            pin_debounce_out   <= pin_ctl.debounce;
            pin_gp_input_out   <= pin_ctl.gp_input;
            pin_gp_output_out  <= pin_ctl.gp_output;
            pin_open_coll_out  <= pin_ctl.open_coll;
            pin_serial_out     <= pin_ctl.serial;
            pin_aux_analog_out <= pin_ctl.aux_analog;
        end
    end

    // Power and setup controls follow their register bits one cycle later.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            aux_smoothing_select_out      <= 2'h0;
            main_converters_powerdown_out <= 1'b0;
            ref_buffer_powerdown_out      <= 1'b0;
            ref_powerdown_out             <= 1'b0;
            dac_powerdown_out             <= 4'h0;
            aux_converter_on_out          <= 1'b0;
            osc_powerdown_out             <= 1'b0;
            dac_init_field_out            <= 2'h0;
        end else begin
            aux_smoothing_select_out <=
                aux_filter_and_power_control[PFPC_SMOOTH_LSB +: 2];
            main_converters_powerdown_out <=
                aux_filter_and_power_control[PFPC_MAIN_PD_BIT];
            ref_buffer_powerdown_out <=
                aux_filter_and_power_control[PFPC_REF_BUF_PD_BIT];
            ref_powerdown_out        <= aux_filter_and_power_control[PFPC_REF_PD_BIT];
            // Bit 3 is DAC0 down to bit 0 for DAC3, so the nibble is reversed here.
            for (int i = 0; i < 4; i++) begin
                dac_powerdown_out[i] <=
                    aux_filter_and_power_control[PFPC_DAC_ZERO_PD_BIT - i];
            end
            aux_converter_on_out <= aux_converter_enable[PFPC_AUX_ON_BIT];
            osc_powerdown_out    <= oscillator_power_down[PFPC_OSC_PD_BIT];
            dac_init_field_out   <= dac_setup[1:0];
        end
    end
endmodule // pfpc_regs

// file: core/pfpc_pkg.sv
// Purpose: Constants for the pin function and power control register bank.
// Assumes: Register addresses are word indices on a plain register port.
// Notes:   All reset values are zero.
package pfpc_pkg;
    localparam int          PFPC_ADDR_W       = 12;
    localparam int          PFPC_DATA_W       = 24;
    localparam int          PFPC_PINS         = 12;
    localparam int          PFPC_PINS_PER_REG = 6;
    localparam logic [11:0] PFPC_PIN_LOW_ADDR  = 12'h820;
    localparam logic [11:0] PFPC_PIN_HIGH_ADDR = 12'h821;
    localparam logic [11:0] PFPC_AUX_PWR_ADDR  = 12'h822;
    localparam logic [11:0] PFPC_AUX_EN_ADDR   = 12'h824;
    localparam logic [11:0] PFPC_OSC_PD_ADDR   = 12'h826;
    localparam logic [11:0] PFPC_DAC_SETUP_ADDR = 12'h827;
    localparam logic [23:0] PFPC_PIN_RESET    = 24'h000000;
    localparam logic [15:0] PFPC_REG16_RESET  = 16'h0000;
    // Writable bit masks; reserved bits store nothing and read as zero.
    localparam logic [15:0] PFPC_AUX_PWR_MASK = 16'h03EF;
    localparam logic [15:0] PFPC_AUX_EN_MASK  = 16'h8000;
    localparam logic [15:0] PFPC_OSC_PD_MASK  = 16'h0004;
    localparam logic [15:0] PFPC_DAC_MASK     = 16'h0003;
    localparam int          PFPC_SMOOTH_LSB       = 8;
    localparam int          PFPC_MAIN_PD_BIT      = 7;
    localparam int          PFPC_REF_BUF_PD_BIT   = 6;
    localparam int          PFPC_REF_PD_BIT       = 5;
    localparam int          PFPC_DAC_ZERO_PD_BIT  = 3;
    localparam int          PFPC_AUX_ON_BIT       = 15;
    localparam int          PFPC_OSC_PD_BIT       = 2;
    localparam logic [2:0]  PFPC_CODE_GPI_DEB = 3'h0;
    localparam logic [2:0]  PFPC_CODE_GPI_RAW = 3'h1;
    localparam logic [2:0]  PFPC_CODE_GPO_PP  = 3'h2;
    localparam logic [2:0]  PFPC_CODE_GPO_OC  = 3'h3;
    localparam logic [2:0]  PFPC_CODE_SERIAL  = 3'h4;
    localparam logic [3:0]  PFPC_CODE_AUX     = 4'hF;

    typedef enum logic [2:0] {
        PFPC_FN_GPI_DEBOUNCE,
        PFPC_FN_GPI_RAW,
        PFPC_FN_GPO_PUSH_PULL,
        PFPC_FN_GPO_OPEN_COLL,
        PFPC_FN_SERIAL,
        PFPC_FN_AUX_ANALOG,
        PFPC_FN_RESERVED
    } pfpc_func_t;
endpackage

// file: core/pfpc_pin_if.sv
// Purpose: Carries per-pin decoded function controls between modules.
// Assumes: One field per multipurpose pin.
// Notes:   Decoder drives, register bank reads.
`timescale 1ns/1ps
interface pfpc_pin_if #(parameter int PINS = 12);
    logic [PINS-1:0] invert;
    logic [PINS-1:0] pull_up;
    logic [PINS-1:0] debounce;
    logic [PINS-1:0] gp_input;
    logic [PINS-1:0] gp_output;
    logic [PINS-1:0] open_coll;
    logic [PINS-1:0] serial;
    logic [PINS-1:0] aux_analog;
    modport decoder (output invert, pull_up, debounce, gp_input, gp_output,
                     open_coll, serial, aux_analog);
    modport user (input invert, pull_up, debounce, gp_input, gp_output,
                  open_coll, serial, aux_analog);
endinterface

// file: core/pfpc_pin_decode.sv
// Purpose: Decodes each 4-bit pin function nibble into control lines.
// Assumes: Nibbles arrive packed, pin n at bits 4n+3 down to 4n.
// Notes:   Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module pfpc_pin_decode
    import pfpc_pkg::*;
#(
    parameter int PINS = 12
) (
    input  wire logic [4*PINS-1:0] nibbles_in,
    pfpc_pin_if.decoder             pins
);
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            logic [3:0] pin_function_nibble;
            pfpc_func_t fn;
            assign pin_function_nibble = nibbles_in[4*g +: 4];
            always_comb begin
                if (pin_function_nibble == PFPC_CODE_AUX) begin
                    fn = PFPC_FN_AUX_ANALOG;
                end else begin
                    // the top bit only inverts, low three bits pick the function.
                    unique case (pin_function_nibble[2:0])
                        PFPC_CODE_GPI_DEB: fn = PFPC_FN_GPI_DEBOUNCE;
                        PFPC_CODE_GPI_RAW: fn = PFPC_FN_GPI_RAW;
                        PFPC_CODE_GPO_PP:  fn = PFPC_FN_GPO_PUSH_PULL;
                        PFPC_CODE_GPO_OC:  fn = PFPC_FN_GPO_OPEN_COLL;
                        PFPC_CODE_SERIAL:  fn = PFPC_FN_SERIAL;
                        default:           fn = PFPC_FN_RESERVED;
                    endcase
                end
            end
            assign pins.invert[g]     = pin_function_nibble[3] && (fn != PFPC_FN_AUX_ANALOG)
                                        && (fn != PFPC_FN_RESERVED);
            assign pins.debounce[g]   = (fn == PFPC_FN_GPI_DEBOUNCE);
            assign pins.gp_input[g]   = (fn == PFPC_FN_GPI_DEBOUNCE) || (fn == PFPC_FN_GPI_RAW);
            assign pins.gp_output[g]  = (fn == PFPC_FN_GPO_PUSH_PULL) || (fn == PFPC_FN_GPO_OPEN_COLL);
            assign pins.open_coll[g]  = (fn == PFPC_FN_GPO_OPEN_COLL);
            assign pins.serial[g]     = (fn == PFPC_FN_SERIAL);
            assign pins.aux_analog[g] = (fn == PFPC_FN_AUX_ANALOG);
            // Lower six pins carry serial data in, upper six carry it out.
            assign pins.pull_up[g]    = pins.gp_input[g]
                                        || ((fn == PFPC_FN_SERIAL) && (g < PINS / 2));
        end
    endgenerate
endmodule // pfpc_pin_decode

// file: verif/pfpc_regs_chk.sv
// Purpose: Concurrent checks on the pin function and power control bank.
// Assumes: Control outputs settle one edge after the write edge.
// Notes:   Checks sleep while reset is low.
`timescale 1ns/1ps
module pfpc_regs_chk
    import pfpc_pkg::*;
#(
    parameter int PINS = PFPC_PINS
) (
    input wire logic                   clk_in,
    input wire logic                   rst_n_in,
    input wire logic [PFPC_ADDR_W-1:0] addr_in,
    input wire logic [PFPC_DATA_W-1:0] wdata_in,
    input wire logic                   wr_in,
    input wire logic                   rd_in,
    input wire logic [PFPC_DATA_W-1:0] rdata_out,
    input wire logic [PINS-1:0]        pin_invert_out,
    input wire logic [PINS-1:0]        pin_pull_up_out,
    input wire logic [PINS-1:0]        pin_debounce_out,
    input wire logic [PINS-1:0]        pin_gp_input_out,
    input wire logic [PINS-1:0]        pin_gp_output_out,
    input wire logic [PINS-1:0]        pin_open_coll_out,
    input wire logic [PINS-1:0]        pin_serial_out,
    input wire logic [PINS-1:0]        pin_aux_analog_out,
    input wire logic                   main_converters_powerdown_out,
    input wire logic [3:0]             dac_powerdown_out,
    input wire logic                   aux_converter_on_out,
    input wire logic                   osc_powerdown_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // A back-to-back second write to the same place is excluded; it would reach the output only after the check.
    sequence wr_to(logic [11:0] a);
        wr_in && addr_in == a ##1 !(wr_in && addr_in == a);
    endsequence
    aux_on_a: assert property (wr_to(PFPC_AUX_EN_ADDR) |=>
        aux_converter_on_out == $past(wdata_in[15], 2)) else $error("aux enable mismatch");
    osc_pd_a: assert property (wr_to(PFPC_OSC_PD_ADDR) |=>
        osc_powerdown_out == $past(wdata_in[2], 2)) else $error("osc power-down mismatch");
    unit_pd_a: assert property (wr_to(PFPC_AUX_PWR_ADDR) |=> dac_powerdown_out[0] ==
        $past(wdata_in[3], 2) && main_converters_powerdown_out == $past(wdata_in[7], 2))
        else $error("power-down bits mismatch");
    rd_idle_a: assert property (!rd_in |=> rdata_out == '0) else $error("stray read data");
    oc_sub_a: assert property ((pin_open_coll_out & ~pin_gp_output_out) == '0)
        else $error("open-collector without output");
    deb_sub_a: assert property ((pin_debounce_out & ~pin_gp_input_out) == '0)
        else $error("debounce without input");
    io_excl_a: assert property ((pin_gp_input_out & pin_gp_output_out) == '0)
        else $error("pin both input and output");
    pull_up_a: assert property (pin_pull_up_out ==
        (pin_gp_input_out | (pin_serial_out & 12'h03F))) else $error("pull-up mismatch");
    aux_only_a: assert property ((pin_aux_analog_out & (pin_invert_out | pin_gp_input_out
        | pin_gp_output_out | pin_serial_out)) == '0) else $error("aux pin has other function");
endmodule // pfpc_regs_chk

// file: verif/tb_pfpc_regs.sv
// Purpose: Self-checking bench for the pin function and power control bank.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes:   A shadow copy of the registers gives every expected value except the zero read from unmapped 12'h823.
`timescale 1ns/1ps
module tb_pfpc_regs;
    import pfpc_pkg::*;
    logic        clk_in, rst_n_in, wr_in, rd_in, rd_seen;
    logic [11:0] addr_in, pi, pp, pd, pgi, pgo, poc, ps, pa;
    logic [23:0] wdata_in, rdata_out, d;
    logic [3:0]  dpd;
    logic [1:0]  smooth, dinit;
    logic        main_pd, rbuf_pd, ref_pd, aux_on, osc_pd;
    logic [23:0] rq[$];
    logic [23:0] shadow[6] = '{default: 24'h000000};
    logic [11:0] ra[6] = '{PFPC_PIN_LOW_ADDR, PFPC_PIN_HIGH_ADDR, PFPC_AUX_PWR_ADDR,
                           PFPC_AUX_EN_ADDR, PFPC_OSC_PD_ADDR, PFPC_DAC_SETUP_ADDR};
    logic [23:0] rm[6] = '{24'hFFFFFF, 24'hFFFFFF, 24'h0003EF, 24'h008000, 24'h000004, 24'h000003};
    logic [108:0] got_ctl;
    int          n_fail, check_count;
    integer      seed = 32'h6A14;
    assign got_ctl = {pi, pp, pd, pgi, pgo, poc, ps, pa, smooth, main_pd, rbuf_pd, ref_pd,
                      dpd, aux_on, osc_pd, dinit};
    pfpc_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .pin_invert_out(pi), .pin_pull_up_out(pp), .pin_debounce_out(pd),
        .pin_gp_input_out(pgi), .pin_gp_output_out(pgo), .pin_open_coll_out(poc),
        .pin_serial_out(ps), .pin_aux_analog_out(pa), .aux_smoothing_select_out(smooth),
        .main_converters_powerdown_out(main_pd), .ref_buffer_powerdown_out(rbuf_pd),
        .ref_powerdown_out(ref_pd), .dac_powerdown_out(dpd), .aux_converter_on_out(aux_on),
        .osc_powerdown_out(osc_pd), .dac_init_field_out(dinit));
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic note(input logic [108:0] got, input logic [108:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_rd(input logic [23:0] got, input logic [23:0] exp);
        note(109'(got), 109'(exp));
    endtask
    task automatic cmp_ctl(input logic [108:0] got, input logic [108:0] exp);
        note(got, exp);
    endtask
    task automatic wr(input logic [11:0] a, input logic [23:0] v);
        wr_in <= 1'b1;
        rd_in <= 1'b0;
        addr_in <= a;
        wdata_in <= v;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [11:0] a, input logic [23:0] exp);
        rd_in <= 1'b1;
        wr_in <= 1'b0;
        addr_in <= a;
        rq.push_back(exp);
        @(posedge clk_in);
    endtask
    task automatic put(input int r, input logic [23:0] v);
        wr(ra[r], v);
        shadow[r] = v & rm[r];
    endtask
    // Returns invert, pull-up, debounce, input, output, open-collector, serial, aux.
    function automatic logic [7:0] pin_exp(input logic [3:0] c, input bit low);
        logic [2:0] b;
        logic       v;
        b = c[2:0];
        v = b <= 3'h4;
        return {c[3] & v, v & (b <= 3'h1 || (b == 3'h4 && low)), v & (b == 3'h0),
                v & (b <= 3'h1), v & (b == 3'h2 || b == 3'h3), v & (b == 3'h3),
                v & (b == 3'h4), c == 4'hF};
    endfunction
    function automatic logic [108:0] exp_all();
        logic [95:0] p;
        logic [7:0]  e;
        logic [47:0] nib;
        nib = {shadow[1], shadow[0]};
        for (int n = 0; n < 12; n++) begin
            e = pin_exp(nib[n*4 +: 4], n < 6);
            for (int k = 0; k < 8; k++) p[k*12+n] = e[k];
        end
        return {p, shadow[2][9:5], shadow[2][0], shadow[2][1], shadow[2][2], shadow[2][3],
                shadow[3][15], shadow[4][2], shadow[5][1:0]};
    endfunction
    task automatic check_ctl;
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        cmp_ctl(got_ctl, exp_all());
        @(posedge clk_in);
    endtask
    always @(posedge clk_in) rd_seen <= rd_in && rst_n_in;
    always @(negedge clk_in) begin
        if (rd_seen) begin
            cmp_rd(rdata_out, rq.pop_front());
        end
    end
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end
    initial begin
        {rst_n_in, wr_in, rd_in, addr_in, wdata_in} = '0;
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int r = 0; r < 6; r++) rd(ra[r], 24'h000000);
        check_ctl();
        // Each write is followed at once by a read, so the new value must be visible.
        for (int i = 0; i < 6; i++) begin
            for (int r = 0; r < 6; r++) begin
                d = 24'($random(seed));
                if (r == 2) d[9:8] = 2'(i);
                put(r, d);
                rd(ra[r], shadow[r]);
            end
            wr(12'h823, 24'($random(seed)));
            rd(12'h823, 24'h000000);
            check_ctl();
        end
        put(5, 24'h000001);
        for (int i = 0; i < 16; i++) begin
            for (int n = 0; n < 12; n++) d[(n%6)*4 +: 4] = 4'(i + n);
            for (int n = 0; n < 6; n++) shadow[0][n*4 +: 4] = 4'(i + n);
            put(0, shadow[0]);
            put(1, d);
            check_ctl();
        end
        // A reset in mid-run must bring every register back to zero.
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        shadow = '{default: 24'h000000};
        for (int r = 0; r < 6; r++) rd(ra[r], 24'h000000);
        check_ctl();
        give_verdict();
    end
endmodule // tb_pfpc_regs
bind pfpc_regs pfpc_regs_chk #(.PINS(PINS)) chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .pin_invert_out(pin_invert_out), .pin_pull_up_out(pin_pull_up_out),
    .pin_debounce_out(pin_debounce_out), .pin_gp_input_out(pin_gp_input_out),
    .pin_gp_output_out(pin_gp_output_out), .pin_open_coll_out(pin_open_coll_out),
    .pin_serial_out(pin_serial_out), .pin_aux_analog_out(pin_aux_analog_out),
    .main_converters_powerdown_out(main_converters_powerdown_out),
    .dac_powerdown_out(dac_powerdown_out), .aux_converter_on_out(aux_converter_on_out),
    .osc_powerdown_out(osc_powerdown_out));
